// file: core/lmbc_pkg.sv
package lmbc_pkg;

  localparam int unsigned SYS_CLK_MHZ = 40;
  localparam int unsigned REFRESH_PERIOD_NS = 15600;
  // Longest allowed spacing, so the cycle count rounds down
  localparam int unsigned REFRESH_CYCLES = REFRESH_PERIOD_NS * SYS_CLK_MHZ / 1000;

  // Sixteen oscillator ticks per memory cycle, four per quarter
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [3:0] ROW_LAST = 4'h4;
  localparam logic [3:0] COL_FIRST = 4'h5;
  localparam logic [3:0] COL_LAST = 4'h7;
  localparam logic [3:0] DATA_FIRST = 4'h8;
  localparam logic [3:0] WSTRB_FIRST = 4'h9;
  localparam logic [3:0] WSTRB_LAST = 4'hE;
  localparam logic [3:0] RDCAP_FIRST = 4'hC;
  localparam logic [3:0] REF_CAS_LAST = 4'h4;
  localparam logic [3:0] REF_RAS_FIRST = 4'h1;
  localparam logic [3:0] REF_RAS_LAST = 4'h5;
  localparam logic [2:0] CLK_B_LAG = 3'h2;

  localparam logic [20:0] BIA_LAST = 21'h00000F;
  localparam logic [20:0] ROM_LO_FIRST = 21'h000010;
  localparam logic [20:0] ROM_LO_LAST = 21'h00FFFF;
  localparam logic [20:0] ROM_HI_FIRST = 21'h1F0000;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_CMD = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_RDATA = 8'h14;

  localparam int unsigned CTRL_SOFT_RESET = 0;
  localparam int unsigned CTRL_REFRESH_EN = 1;
  localparam int unsigned CMD_START = 0;
  localparam int unsigned CMD_WRITE = 1;
  localparam int unsigned STAT_PAR_ERR = 3;
  localparam logic [1:0] CTRL_RESET = 2'h2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    CY_IDLE = 2'b00,
    CY_ACCESS = 2'b01,
    CY_REFRESH = 2'b11
  } lmbc_cycle_t;

  typedef struct packed {
    logic [7:0] o;
    logic oe;
  } lmbc_byte_pin_t;

  typedef struct packed {
    logic o;
    logic oe;
  } lmbc_bit_pin_t;

  typedef struct packed {
    logic local_bus_clock_a;
    logic local_bus_clock_b;
    logic divided_clock_output;
    logic glue_reset_n;
    logic row_strobe_n;
    logic column_strobe_n;
    logic local_write_strobe_n;
    logic dram_output_enable_n;
    logic buffer_enable_n;
    logic buffer_direction;
    logic id_rom_enable_n;
    logic boot_rom_select_n;
    logic refresh_cycle_flag;
    logic address_latch_strobe;
    logic ext_addr_pin_zero;
    logic ext_addr_pin_two;
  } lmbc_strobe_t;

  localparam lmbc_strobe_t STROBE_RESET = 16'h0FB0;

endpackage : lmbc_pkg

// file: core/lmbc_top.sv
`timescale 1ns/1ps
module lmbc_top
  import lmbc_pkg::*;
#(
  parameter int unsigned REFRESH_INTERVAL = REFRESH_CYCLES
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic system_reset_n,
  input wire logic bootstrap_input,
  input wire logic parity_check_enable,
  input wire logic clock_divider_select,
  input wire logic [7:0] addr_data_hi_in,
  input wire logic [7:0] addr_data_lo_in,
  input wire logic ext_addr_parity_hi_in,
  input wire logic ext_addr_parity_lo_in,
  output lmbc_byte_pin_t addr_data_hi_byte,
  output lmbc_byte_pin_t addr_data_lo_byte,
  output lmbc_bit_pin_t ext_addr_parity_hi,
  output lmbc_bit_pin_t ext_addr_parity_lo,
  output lmbc_strobe_t mem_strobes
);

  localparam int SW = 22;

  // Pin synchronisers: a bit changes once stages two and three agree
  logic [SW-1:0] pin_raw;
  logic [SW-1:0] sync1_reg;
  logic [SW-1:0] sync2_reg;
  logic [SW-1:0] sync3_reg;
  logic [SW-1:0] pin_reg;
  assign pin_raw = {system_reset_n, bootstrap_input, parity_check_enable, clock_divider_select,
                    addr_data_hi_in, addr_data_lo_in, ext_addr_parity_hi_in,
                    ext_addr_parity_lo_in};

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < SW; gi++) begin : g_pin
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          pin_reg[gi] <= 1'b0;
        end else if (sync2_reg[gi] == sync3_reg[gi]) begin
          pin_reg[gi] <= sync3_reg[gi];
        end
      end
    end
  endgenerate

  logic [7:0] hi_pin;
  logic [7:0] lo_pin;
  assign hi_pin = pin_reg[17:10];
  assign lo_pin = pin_reg[9:2];

  // Control and status state
  logic [1:0] ctrl_reg;
  logic [20:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic boot_sel_reg;
  logic par_chk_reg;
  logic par_err_reg;
  logic req_pend_reg;
  logic req_write_reg;
  logic ref_pend_reg;
  logic [9:0] ref_cnt_reg;
  logic [7:0] ref_row_reg;
  logic [3:0] tick_reg;
  lmbc_cycle_t cycle_reg;
  logic [20:0] cur_addr_reg;
  logic cur_write_reg;
  logic [15:0] cur_wdata_reg;
  logic in_reset;
  logic busy;
  logic dispatch_acc;
  logic dispatch_ref;

  assign in_reset = !pin_reg[21] || ctrl_reg[CTRL_SOFT_RESET];
  assign busy = req_pend_reg || (cycle_reg == CY_ACCESS);
  assign dispatch_ref = (tick_reg == TICK_LAST) && !in_reset && ref_pend_reg;
  assign dispatch_acc = (tick_reg == TICK_LAST) && !in_reset && !ref_pend_reg && req_pend_reg;

  // AXI4-Lite slave
  logic awready_reg;
  logic wready_reg;
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_out_reg;
  logic [1:0] rresp_reg;
  logic wr_fire;
  logic [31:0] wmask;
  assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}},
                  {8{w_strb_reg[0]}}};

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      awready_reg <= 1'b1;
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (s_axi_awvalid && awready_reg) begin
      awready_reg <= 1'b0;
      aw_hold_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (bvalid_reg && s_axi_bready) begin
      awready_reg <= 1'b1;
      aw_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wready_reg <= 1'b1;
      w_hold_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid && wready_reg) begin
      wready_reg <= 1'b0;
      w_hold_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (bvalid_reg && s_axi_bready) begin
      wready_reg <= 1'b1;
      w_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      if (aw_addr_reg == REG_CTRL || aw_addr_reg == REG_ADDR || aw_addr_reg == REG_WDATA ||
          aw_addr_reg == REG_CMD || aw_addr_reg == REG_STATUS) begin
        bresp_reg <= RESP_OKAY;
      end else begin
        bresp_reg <= RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg <= CTRL_RESET;
      addr_reg <= 21'h000000;
      wdata_reg <= 16'h0000;
    end else if (wr_fire) begin
      if (aw_addr_reg == REG_CTRL) begin
        ctrl_reg <= (ctrl_reg & ~wmask[1:0]) | (w_data_reg[1:0] & wmask[1:0]);
      end else if (aw_addr_reg == REG_ADDR) begin
        addr_reg <= (addr_reg & ~wmask[20:0]) | (w_data_reg[20:0] & wmask[20:0]);
      end else if (aw_addr_reg == REG_WDATA) begin
        wdata_reg <= (wdata_reg & ~wmask[15:0]) | (w_data_reg[15:0] & wmask[15:0]);
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_out_reg <= 32'h00000000;
      rresp_reg <= RESP_OKAY;
    end else if (s_axi_arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rresp_reg <= RESP_OKAY;
      if (s_axi_araddr == REG_CTRL) begin
        rdata_out_reg <= {30'h00000000, ctrl_reg};
      end else if (s_axi_araddr == REG_ADDR) begin
        rdata_out_reg <= {11'h000, addr_reg};
      end else if (s_axi_araddr == REG_WDATA) begin
        rdata_out_reg <= {16'h0000, wdata_reg};
      end else if (s_axi_araddr == REG_CMD) begin
        rdata_out_reg <= {30'h00000000, req_write_reg, busy};
      end else if (s_axi_araddr == REG_STATUS) begin
        rdata_out_reg <= {27'h0000000, in_reset, par_err_reg, par_chk_reg, boot_sel_reg, busy};
      end else if (s_axi_araddr == REG_RDATA) begin
        rdata_out_reg <= {16'h0000, rdata_reg};
      end else begin
        rdata_out_reg <= 32'h00000000;
        rresp_reg <= RESP_SLVERR;
      end
    end else if (rvalid_reg && s_axi_rready) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
    end
  end

  // Straps follow their pins for as long as the reset pin or the soft reset bit holds; sys_rst clears them
  // One cycle more, as the reset pin and the straps leave the synchroniser together
  logic strap_hold_reg;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      boot_sel_reg <= 1'b0;
      par_chk_reg <= 1'b0;
      strap_hold_reg <= 1'b1;
    end else begin
      strap_hold_reg <= in_reset;
      if (in_reset || strap_hold_reg) begin
        boot_sel_reg <= pin_reg[20];
        par_chk_reg <= pin_reg[19];
      end
    end
  end

  // Access request from software, taken only while no access is pending or running
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      req_pend_reg <= 1'b0;
      req_write_reg <= 1'b0;
    end else if (wr_fire && aw_addr_reg == REG_CMD && w_strb_reg[0] &&
                 w_data_reg[CMD_START] && !busy) begin
      req_pend_reg <= 1'b1;
      req_write_reg <= w_data_reg[CMD_WRITE];
    end else if (dispatch_acc) begin
      req_pend_reg <= 1'b0;
    end
  end

  // Refresh timer; a new due refresh wins over its own dispatch
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_cnt_reg <= 10'h000;
      ref_pend_reg <= 1'b0;
    end else begin
      if (ref_cnt_reg == 10'h000) begin
        ref_cnt_reg <= 10'(REFRESH_INTERVAL - 1);
      end else begin
        ref_cnt_reg <= ref_cnt_reg - 10'h001;
      end
      if (ref_cnt_reg == 10'h000 && ctrl_reg[CTRL_REFRESH_EN]) begin
        ref_pend_reg <= 1'b1;
      end else if (dispatch_ref) begin
        ref_pend_reg <= 1'b0;
      end
    end
  end

  // Cycle sequencer: one decision per sixteen ticks
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_reg <= 4'h0;
      cycle_reg <= CY_IDLE;
      cur_addr_reg <= 21'h000000;
      cur_write_reg <= 1'b0;
      cur_wdata_reg <= 16'h0000;
      ref_row_reg <= 8'h00;
    end else begin
      tick_reg <= tick_reg + 4'h1;
      if (tick_reg == TICK_LAST) begin
        case (1'b1)
          dispatch_ref: begin
            cycle_reg <= CY_REFRESH;
            ref_row_reg <= ref_row_reg + 8'h01;
          end
          dispatch_acc: begin
            cycle_reg <= CY_ACCESS;
            cur_addr_reg <= addr_reg;
            cur_write_reg <= req_write_reg;
            cur_wdata_reg <= wdata_reg;
          end
          default: cycle_reg <= CY_IDLE;
        endcase
      end
    end
  end

  // Read data capture and odd parity check
  logic rd_cycle;
  assign rd_cycle = (cycle_reg == CY_ACCESS) && !cur_write_reg;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_reg <= 16'h0000;
    end else if (rd_cycle && tick_reg >= RDCAP_FIRST) begin
      rdata_reg <= {hi_pin, lo_pin};
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      par_err_reg <= 1'b0;
    end else if (rd_cycle && tick_reg == TICK_LAST && par_chk_reg &&
                 (pin_reg[1] != ~^hi_pin || pin_reg[0] != ~^lo_pin)) begin
      par_err_reg <= 1'b1;
    end else if (wr_fire && aw_addr_reg == REG_STATUS && w_strb_reg[0] &&
                 w_data_reg[STAT_PAR_ERR]) begin
      par_err_reg <= 1'b0;
    end
  end

  // Pin values for the current tick, registered below
  logic acc;
  logic refr;
  logic wr_cycle;
  logic is_bia;
  logic is_rom;
  logic [1:0] quarter;
  logic [2:0] lag_phase;
  lmbc_strobe_t str_next;
  lmbc_byte_pin_t hi_next;
  lmbc_byte_pin_t lo_next;
  lmbc_bit_pin_t ph_next;
  lmbc_bit_pin_t pl_next;

  assign acc = cycle_reg == CY_ACCESS;
  assign refr = cycle_reg == CY_REFRESH;
  assign wr_cycle = acc && cur_write_reg;
  assign is_bia = cur_addr_reg <= BIA_LAST;
  assign is_rom = !boot_sel_reg && ((cur_addr_reg >= ROM_LO_FIRST && cur_addr_reg <= ROM_LO_LAST)
                  || cur_addr_reg >= ROM_HI_FIRST);
  assign quarter = tick_reg[3:2];
  assign lag_phase = tick_reg[2:0] - CLK_B_LAG;

  always_comb begin
    str_next.local_bus_clock_a = !tick_reg[2];
    str_next.local_bus_clock_b = !lag_phase[2];
    str_next.divided_clock_output = !tick_reg[2] && pin_reg[18];
    str_next.glue_reset_n = !in_reset;
    str_next.row_strobe_n = !((acc && tick_reg <= ROW_LAST) ||
                              (refr && tick_reg >= REF_RAS_FIRST && tick_reg <= REF_RAS_LAST));
    str_next.column_strobe_n = !((acc && !is_bia && !is_rom &&
                                  tick_reg >= COL_FIRST && tick_reg <= COL_LAST) ||
                                 (refr && tick_reg <= REF_CAS_LAST));
    str_next.local_write_strobe_n = !(wr_cycle && tick_reg >= WSTRB_FIRST &&
                                      tick_reg <= WSTRB_LAST);
    str_next.dram_output_enable_n = !(rd_cycle && !is_bia && !is_rom &&
                                      tick_reg >= DATA_FIRST);
    str_next.buffer_enable_n = !(acc && tick_reg >= DATA_FIRST);
    str_next.buffer_direction = wr_cycle;
    str_next.id_rom_enable_n = !(rd_cycle && is_bia);
    if (tick_reg <= ROW_LAST) begin
      str_next.boot_rom_select_n = !(rd_cycle && is_rom);
    end else begin
      str_next.boot_rom_select_n = cur_addr_reg[2];
    end
    str_next.refresh_cycle_flag = refr;
    str_next.address_latch_strobe = (acc || refr) && tick_reg == 4'h0;
    str_next.ext_addr_pin_zero = (quarter == 2'h0) ? cur_addr_reg[20] : cur_addr_reg[3];
    str_next.ext_addr_pin_two = (quarter == 2'h0) ? cur_addr_reg[18] : cur_addr_reg[1];
    case (quarter)
      2'h0: begin
        lo_next.o = cur_addr_reg[8:1];
        hi_next.o = {cur_addr_reg[16], cur_addr_reg[15:9]};
        ph_next.o = cur_addr_reg[19];
        pl_next.o = cur_addr_reg[17];
      end
      2'h1: begin
        lo_next.o = {cur_addr_reg[16], cur_addr_reg[15:9]};
        hi_next.o = {cur_write_reg, refr, 6'h00};
        ph_next.o = cur_addr_reg[20];
        pl_next.o = cur_addr_reg[18];
      end
      default: begin
        lo_next.o = cur_wdata_reg[7:0];
        hi_next.o = cur_wdata_reg[15:8];
        ph_next.o = ~^cur_wdata_reg[15:8];
        pl_next.o = ~^cur_wdata_reg[7:0];
      end
    endcase
    if (refr) begin
      lo_next.o = ref_row_reg;
    end
    lo_next.oe = (quarter[1] == 1'b0) ? (acc || refr) : wr_cycle;
    hi_next.oe = lo_next.oe;
    ph_next.oe = lo_next.oe;
    pl_next.oe = lo_next.oe;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_strobes <= STROBE_RESET;
      addr_data_hi_byte <= '0;
      addr_data_lo_byte <= '0;
      ext_addr_parity_hi <= '0;
      ext_addr_parity_lo <= '0;
    end else begin
      mem_strobes <= str_next;
      addr_data_hi_byte <= hi_next;
      addr_data_lo_byte <= lo_next;
      ext_addr_parity_hi <= ph_next;
      ext_addr_parity_lo <= pl_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_out_reg;
  assign s_axi_rresp = rresp_reg;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_ras_width: assert property ($fell(mem_strobes.row_strobe_n) &&
    !mem_strobes.refresh_cycle_flag |-> (!mem_strobes.row_strobe_n)[*5]
    ##1 mem_strobes.row_strobe_n) else $error("row strobe width wrong");
  a_cas_width: assert property ($fell(mem_strobes.column_strobe_n) &&
    !mem_strobes.refresh_cycle_flag |-> mem_strobes.row_strobe_n
    ##0 (!mem_strobes.column_strobe_n)[*3] ##1 mem_strobes.column_strobe_n)
    else $error("column strobe width wrong");
  a_refresh_cbr: assert property ($fell(mem_strobes.row_strobe_n) &&
    mem_strobes.refresh_cycle_flag |-> !mem_strobes.column_strobe_n &&
    !$past(mem_strobes.column_strobe_n)) else $error("refresh not CAS before RAS");
  a_clock_div: assert property ($rose(mem_strobes.local_bus_clock_a) |->
    mem_strobes.local_bus_clock_a[*4] ##1 (!mem_strobes.local_bus_clock_a)[*4]
    ##1 mem_strobes.local_bus_clock_a) else $error("bus clock not divide by 8");
  a_clock_lag: assert property ($rose(mem_strobes.local_bus_clock_a) |->
    ##2 $rose(mem_strobes.local_bus_clock_b)) else $error("second clock lag wrong");
  a_dir_first: assert property ($fell(mem_strobes.buffer_enable_n) |->
    $stable(mem_strobes.buffer_direction)) else $error("direction changed at enable");
  a_write_data: assert property (!mem_strobes.local_write_strobe_n |->
    mem_strobes.buffer_direction && addr_data_lo_byte.oe && addr_data_hi_byte.oe &&
    $stable(addr_data_lo_byte.o)) else $error("write data not held");
  a_id_rom_read: assert property (!mem_strobes.id_rom_enable_n |->
    !mem_strobes.buffer_direction && mem_strobes.column_strobe_n)
    else $error("id rom enable on bad cycle");
  a_dram_oe: assert property (!mem_strobes.dram_output_enable_n |->
    !mem_strobes.buffer_direction && mem_strobes.id_rom_enable_n &&
    !mem_strobes.buffer_enable_n) else $error("dram output enable wrong");
  a_glue_reset: assert property (ctrl_reg[CTRL_SOFT_RESET] |->
    ##1 !mem_strobes.glue_reset_n) else $error("glue reset not driven");
  a_parity_hi: assert property (addr_data_hi_byte.oe && !mem_strobes.buffer_enable_n |->
    ext_addr_parity_hi.o == ~^addr_data_hi_byte.o) else $error("high parity wrong");

  c_write: cover property (!mem_strobes.local_write_strobe_n);
  c_read: cover property (!mem_strobes.dram_output_enable_n);
  c_refresh: cover property ($rose(mem_strobes.refresh_cycle_flag));
  c_par_err: cover property ($rose(par_err_reg));

endmodule : lmbc_top

// file: test/lmbc_mem_model.sv
`timescale 1ns/1ps
module lmbc_mem_model
  import lmbc_pkg::*;
(
  input wire logic clk,
  input wire lmbc_byte_pin_t hi,
  input wire lmbc_byte_pin_t lo,
  input wire lmbc_strobe_t st,
  output logic [7:0] hi_in,
  output logic [7:0] lo_in,
  output logic par_hi,
  output logic par_lo
);
  logic [15:0] mem [256];
  logic [7:0] row_reg;
  logic wr_reg = 1'b1;
  logic tgl_reg = 1'b0;
  logic drive;
  always_ff @(posedge clk) begin
    tgl_reg <= ~tgl_reg;
    wr_reg <= st.local_write_strobe_n;
    if (st.address_latch_strobe) row_reg <= lo.o;
    // Store on the strobe's rising edge, as static RAM does
    if (st.local_write_strobe_n && !wr_reg) mem[row_reg] <= {hi.o, lo.o};
  end
  // Released lines toggle every cycle so a stale value never looks valid
  assign drive = !st.buffer_enable_n && !st.buffer_direction;
  assign hi_in = drive ? mem[row_reg][15:8] : {8{tgl_reg}};
  assign lo_in = drive ? mem[row_reg][7:0] : {8{~tgl_reg}};
  assign par_hi = drive ? ~^hi_in : tgl_reg;
  assign par_lo = drive ? ~^lo_in : ~tgl_reg;
endmodule : lmbc_mem_model

// file: test/lmbc_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end
module local_memory_bus_controller_bench;
  import lmbc_pkg::*;
  logic sys_clk = 1'b0, sys_rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic system_reset_n = 1'b1, bootstrap_input = 1'b1;
  logic parity_check_enable = 1'b1, clock_divider_select = 1'b1;
  logic [7:0] addr_data_hi_in, addr_data_lo_in;
  logic ext_addr_parity_hi_in, ext_addr_parity_lo_in;
  lmbc_byte_pin_t addr_data_hi_byte, addr_data_lo_byte;
  lmbc_bit_pin_t ext_addr_parity_hi, ext_addr_parity_lo;
  lmbc_strobe_t mem_strobes;
  int errors = 0, n_checks = 0, cyc = 0;
  logic saw_bia, saw_cas, saw_rom, saw_oe, saw_div, saw_ref = 1'b0;

  lmbc_top #(.REFRESH_INTERVAL(40)) DUT (.*);
  lmbc_mem_model mem_model (.clk(sys_clk), .hi(addr_data_hi_byte), .lo(addr_data_lo_byte),
    .st(mem_strobes), .hi_in(addr_data_hi_in), .lo_in(addr_data_lo_in),
    .par_hi(ext_addr_parity_hi_in), .par_lo(ext_addr_parity_lo_in));

  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic close_out();
    if (errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out

  always @(posedge sys_clk) begin
    cyc++;
    if (!mem_strobes.id_rom_enable_n) saw_bia = 1'b1;
    if (!mem_strobes.column_strobe_n && !mem_strobes.refresh_cycle_flag) saw_cas = 1'b1;
    if (mem_strobes.refresh_cycle_flag) saw_ref = 1'b1;
    if (!mem_strobes.boot_rom_select_n && !mem_strobes.row_strobe_n &&
        !mem_strobes.refresh_cycle_flag) saw_rom = 1'b1;
    if (!mem_strobes.dram_output_enable_n) saw_oe = 1'b1;
    if (mem_strobes.divided_clock_output) saw_div = 1'b1;
    if (cyc == 20000) begin
      errors++;
      close_out();
    end
  end

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask : axi_rd

  task automatic mem_op(input logic [20:0] a, input logic wr);
    logic [1:0] r;
    logic [31:0] d;
    axi_wr(REG_ADDR, {11'h000, a}, r);
    saw_bia = 1'b0;
    saw_cas = 1'b0;
    saw_rom = 1'b0;
    saw_oe = 1'b0;
    axi_wr(REG_CMD, {30'h0, wr, 1'b1}, r);
    d = 32'h1;
    for (int i = 0; i < 100 && d[0]; i++) axi_rd(REG_CMD, d, r);
    `CHK("busy", 1'b0, d[0])
  endtask : mem_op

  initial begin
    logic [1:0] r;
    logic [31:0] d;
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    axi_rd(REG_CTRL, d, r);
    `CHK("ctrl", 32'h2, d)
    axi_rd(8'h40, d, r);
    `CHK("rresp", RESP_SLVERR, r)
    axi_wr(8'h40, 32'h0, r);
    `CHK("bresp", RESP_SLVERR, r)
    axi_wr(REG_WDATA, 32'h0000A55A, r);
    mem_op(21'h000100, 1'b1);
    `CHK("wr cas", 1'b1, saw_cas)
    `CHK("wr id", 1'b0, saw_bia)
    `CHK("wr rom", 1'b0, saw_rom)
    mem_op(21'h000100, 1'b0);
    `CHK("dram oe", 1'b1, saw_oe)
    axi_rd(REG_RDATA, d, r);
    `CHK("rdata", 32'h0000A55A, d)
    axi_rd(REG_STATUS, d, r);
    `CHK("par err", 1'b0, d[STAT_PAR_ERR])
    mem_op(21'h000004, 1'b0);
    `CHK("id rd", 1'b1, saw_bia)
    `CHK("id cas", 1'b0, saw_cas)
    `CHK("id oe", 1'b0, saw_oe)
    mem_op(21'h000004, 1'b1);
    `CHK("id wr", 1'b0, saw_bia)
    `CHK("refresh", 1'b1, saw_ref)
    axi_wr(REG_CTRL, 32'h3, r);
    repeat (2) @(posedge sys_clk);
    `CHK("glue", 1'b0, mem_strobes.glue_reset_n)
    axi_wr(REG_CTRL, 32'h2, r);
    repeat (2) @(posedge sys_clk);
    `CHK("glue", 1'b1, mem_strobes.glue_reset_n)
    `CHK("div on", 1'b1, saw_div)
    system_reset_n <= 1'b0;
    bootstrap_input <= 1'b0;
    clock_divider_select <= 1'b0;
    repeat (8) @(posedge sys_clk);
    saw_div = 1'b0;
    `CHK("sys glue", 1'b0, mem_strobes.glue_reset_n)
    system_reset_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    `CHK("div off", 1'b0, saw_div)
    axi_rd(REG_STATUS, d, r);
    `CHK("straps", 5'h04, d[4:0])
    mem_op(21'h000100, 1'b0);
    `CHK("rom cas", 1'b0, saw_cas)
    `CHK("rom sel", 1'b1, saw_rom)
    `CHK("rom oe", 1'b0, saw_oe)
    close_out();
  end
endmodule : local_memory_bus_controller_bench
